/* File: bur_top.sv */
// Banked UART register interface with transmitter, receiver and queues
//
// Local design decision: the strobed register port.
`timescale 1ns/100ps
module bur_top import bur_pkg::*; (
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  // Register port
  input  wire logic [2:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // Serial line and modem pins, modem order dcd ri dsr cts
  input  wire logic       i_sin,
  input  wire logic [3:0] i_modem,
  output logic            o_sout,
  output logic            o_rts,
  output logic            o_dtr,
  // Interrupt
  output logic            o_irq
);

  logic [7:0]  bsel_ff, ier_ff, fcr_ff, mcr_ff, spr_ff, x1_ff, x2_ff, ist_ff, rdata_ff;
  bur_line_t   line_ff;
  logic [15:0] ldiv_ff, xdiv_ff, tk_ff, rc_ff;
  logic [7:0]  txq [16];
  bur_rxw_t    rxq [16];
  logic [3:0]  twp_ff, trp_ff, rwp_ff, rrp_ff;
  logic [4:0]  tq_n_ff, rq_n_ff;
  bur_st_t     tst_ff, rst_ff;
  logic [7:0]  tsh_ff, rsh_ff;
  logic [2:0]  tbit_ff, rbit_ff;
  logic        tpar_ff, txo_ff, rpe_ff, tout_ff, txe_ff;
  logic        s1_ff, s2_ff, rprev_ff;
  logic [3:0]  m1_ff, m2_ff, mprev_ff, msd_ff, lerr_ff;
  logic [5:0]  to_ff;
  logic        sout_ff, rts_ff, dtr_ff, irq_ff;

  logic [1:0]  bank;
  logic        ext, lpbk, fen, tick, rxin;
  logic [15:0] bt;
  logic [2:0]  lastb;
  logic [4:0]  tlim, rlim, thr;
  logic        lcr_wr, txd_wr, fcr_wr, rxd_rd, lsr_rd, msr_rd;
  logic        tx_clr, rx_clr, tx_push, tx_pop, rx_done, rx_push, rx_pop, tout_set;
  logic [7:0]  rdat, ev, mux, event_identification;
  logic [3:0]  msd_set;
  logic [3:0]  lerr_set;

  function automatic logic parbit(input logic [7:0] d, input bur_line_t l);
    logic [7:0] m;
    m = 8'hFF >> (2'd3 - l.wls);
    parbit = l.stkp ? ~l.eps : (^(d & m)) ^ ~l.eps;
  endfunction : parbit

  always_comb begin
    if (!bsel_ff[7]) begin
      bank = 2'd0;
    end else if (!bsel_ff[6] || bsel_ff[1] || bsel_ff[0]) begin
      bank = 2'd1;
    end else if (bsel_ff == BSEL_B2) begin
      bank = 2'd2;
    end else if (bsel_ff == BSEL_B3) begin
      bank = 2'd3;
    end else begin
      bank = 2'd0;
    end
  end

  assign ext   = x1_ff[X1_EXT];
  assign lpbk  = ext ? x1_ff[X1_LOOP] : mcr_ff[MCR_LOOP];
  assign fen   = fcr_ff[FCR_EN];
  assign tlim  = fen ? TXQ_LIM : 5'h01;
  assign rlim  = fen ? RXQ_LIM : 5'h01;
  assign lastb = {1'b0, line_ff.wls} + 3'd4;
  // offset 3 decoded in every bank
  assign lcr_wr = i_wr && i_addr == OFF_LCR;
  assign txd_wr = i_wr && bank == 2'd0 && i_addr == OFF_DATA;
  assign rxd_rd = i_rd && bank == 2'd0 && i_addr == OFF_DATA;
  assign fcr_wr = i_wr && bank == 2'd0 && i_addr == OFF_EIR;
  assign lsr_rd = i_rd && bank == 2'd0 && i_addr == OFF_LSR;
  assign msr_rd = i_rd && bank == 2'd0 && i_addr == OFF_MSR;
  // Changing the enable flushes both queues so no stale depth survives
  assign tx_clr = fcr_wr && (i_wdata[FCR_TXSR] || i_wdata[FCR_EN] != fen);
  assign rx_clr = fcr_wr && (i_wdata[FCR_RXSR] || i_wdata[FCR_EN] != fen);

  always_comb begin
    case (fcr_ff[7:6])
      2'd0:    thr = THR_0;
      2'd1:    thr = THR_1;
      2'd2:    thr = THR_2;
      default: thr = THR_3;
    endcase
  end

  // Configuration registers
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      bsel_ff <= RST_BYTE;
      line_ff <= bur_line_t'(7'h00);
      ier_ff  <= RST_BYTE;
      fcr_ff  <= RST_BYTE;
      mcr_ff  <= RST_BYTE;
      spr_ff  <= RST_BYTE;
      x1_ff   <= RST_BYTE;
      x2_ff   <= RST_BYTE;
      ldiv_ff <= RST_DIV;
      xdiv_ff <= RST_DIV;
    end else begin
      // bank code does not touch line settings
      if (lcr_wr) begin
        bsel_ff <= i_wdata;
        if (!i_wdata[LCR_BANK_SELECT_ENABLE]) begin
          line_ff <= bur_line_t'(i_wdata[6:0]);
        end
      end
      if (i_wr) begin
        case (bank)
          2'd0: begin
            case (i_addr)
              OFF_IER: ier_ff <= i_wdata & (ext ? IER_EXT : IER_LEG);
              OFF_EIR: fcr_ff <= i_wdata & FCR_KEEP;
              OFF_MCR: mcr_ff <= i_wdata;
              OFF_AUX: if (!ext) begin
                spr_ff <= i_wdata;
              end
              default: ;
            endcase
          end
          2'd1: begin
            if (i_addr == OFF_DIVL) begin
              ldiv_ff[7:0] <= i_wdata;
            end
            if (i_addr == OFF_DIVH) begin
              ldiv_ff[15:8] <= i_wdata;
            end
          end
          2'd2: begin
            case (i_addr)
              OFF_DIVL: xdiv_ff[7:0]  <= i_wdata;
              OFF_DIVH: xdiv_ff[15:8] <= i_wdata;
              OFF_X1:   x1_ff         <= i_wdata;
              OFF_X2:   x2_ff         <= i_wdata;
              default: ;
            endcase
          end
          default: ;
        endcase
      end
    end
  end

  // Bit tick; a zero divisor is taken as one, a smaller divisor reloads at once
  assign bt   = ((ext ? xdiv_ff : ldiv_ff) == 16'h0000) ? 16'h0001 : (ext ? xdiv_ff : ldiv_ff);
  assign tick = tk_ff == 16'h0000;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      tk_ff <= 16'h0000;
    end else begin
      tk_ff <= (tick || tk_ff >= bt) ? bt - 16'h0001 : tk_ff - 16'h0001;
    end
  end

  // Transmit queue
  assign tx_push = txd_wr && tq_n_ff < tlim;
  assign tx_pop  = tst_ff == S_IDLE && tick && tq_n_ff != 5'h00;

  always_ff @(posedge i_ref_clk) begin
    if (tx_push) begin
      txq[twp_ff] <= i_wdata;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      twp_ff  <= 4'h0;
      trp_ff  <= 4'h0;
      tq_n_ff <= 5'h00;
    end else if (tx_clr) begin
      twp_ff  <= 4'h0;
      trp_ff  <= 4'h0;
      tq_n_ff <= 5'h00;
    end else begin
      twp_ff  <= twp_ff + {3'h0, tx_push};
      trp_ff  <= trp_ff + {3'h0, tx_pop};
      tq_n_ff <= tq_n_ff + {4'h0, tx_push} - {4'h0, tx_pop};
    end
  end

  // transmit framing, one state per bit tick
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      tst_ff  <= S_IDLE;
      tsh_ff  <= 8'h00;
      tbit_ff <= 3'h0;
      tpar_ff <= 1'b0;
      txo_ff  <= 1'b1;
    end else if (tick) begin
      case (tst_ff)
        S_IDLE: if (tx_pop) begin
          tsh_ff  <= txq[trp_ff];
          tpar_ff <= parbit(txq[trp_ff], line_ff);
          txo_ff  <= 1'b0;
          tst_ff  <= S_START;
        end
        S_START: begin
          txo_ff  <= tsh_ff[0];
          tbit_ff <= 3'h0;
          tst_ff  <= S_DATA;
        end
        S_DATA: begin
          tsh_ff <= tsh_ff >> 1;
          if (tbit_ff != lastb) begin
            tbit_ff <= tbit_ff + 3'd1;
            txo_ff  <= tsh_ff[1];
          end else if (line_ff.pen) begin
            txo_ff <= tpar_ff;
            tst_ff <= S_PAR;
          end else begin
            txo_ff <= 1'b1;
            tst_ff <= line_ff.stb ? S_STOP : S_IDLE;
          end
        end
        S_PAR: begin
          txo_ff <= 1'b1;
          tst_ff <= line_ff.stb ? S_STOP : S_IDLE;
        end
        S_STOP: tst_ff <= S_IDLE;
        default: tst_ff <= S_IDLE;
      endcase
    end
  end

  // Input synchronisers
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_ff    <= 1'b1;
      s2_ff    <= 1'b1;
      rprev_ff <= 1'b1;
      m1_ff    <= 4'h0;
      m2_ff    <= 4'h0;
      mprev_ff <= 4'h0;
    end else begin
      s1_ff    <= i_sin;
      s2_ff    <= s1_ff;
      rprev_ff <= rxin;
      m1_ff    <= i_modem;
      m2_ff    <= m1_ff;
      mprev_ff <= m2_ff;
    end
  end

  assign rxin    = lpbk ? txo_ff : s2_ff;
  assign rdat    = rsh_ff >> (2'd3 - line_ff.wls);
  assign rx_done = rst_ff == S_STOP && rc_ff == 16'h0000;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rst_ff  <= S_IDLE;
      rc_ff   <= 16'h0000;
      rsh_ff  <= 8'h00;
      rbit_ff <= 3'h0;
      rpe_ff  <= 1'b0;
    end else if (rst_ff == S_IDLE) begin
      if (rprev_ff && !rxin) begin
        rc_ff  <= bt >> 1;
        rst_ff <= S_START;
      end
    end else if (rc_ff != 16'h0000) begin
      rc_ff <= rc_ff - 16'h0001;
    end else begin
      rc_ff <= bt - 16'h0001;
      case (rst_ff)
        S_START: begin
          rbit_ff <= 3'h0;
          rpe_ff  <= 1'b0;
          rst_ff  <= rxin ? S_IDLE : S_DATA;
        end
        S_DATA: begin
          rsh_ff <= {rxin, rsh_ff[7:1]};
          if (rbit_ff != lastb) begin
            rbit_ff <= rbit_ff + 3'd1;
          end else begin
            rst_ff <= line_ff.pen ? S_PAR : S_STOP;
          end
        end
        S_PAR: begin
          rpe_ff <= rxin ^ parbit(rdat, line_ff);
          rst_ff <= S_STOP;
        end
        default: rst_ff <= S_IDLE;
      endcase
    end
  end

  // Receive queue, overrun drops the new character
  assign rx_push = rx_done && rq_n_ff < rlim && !rx_clr;
  assign rx_pop  = rxd_rd && rq_n_ff != 5'h00;

  always_ff @(posedge i_ref_clk) begin
    if (rx_push) begin
      rxq[rwp_ff] <= '{brk: !rxin && rdat == 8'h00, fe: !rxin, pe: rpe_ff, data: rdat};
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rwp_ff  <= 4'h0;
      rrp_ff  <= 4'h0;
      rq_n_ff <= 5'h00;
    end else if (rx_clr) begin
      rwp_ff  <= 4'h0;
      rrp_ff  <= 4'h0;
      rq_n_ff <= 5'h00;
    end else begin
      rwp_ff  <= rwp_ff + {3'h0, rx_push};
      rrp_ff  <= rrp_ff + {3'h0, rx_pop};
      rq_n_ff <= rq_n_ff + {4'h0, rx_push} - {4'h0, rx_pop};
    end
  end

  // receive timeout after idle bit times
  assign tout_set = tick && to_ff == TOUT_BITS - 6'h01 && !rx_push && !rx_pop && rq_n_ff != 5'h00;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      to_ff   <= 6'h00;
      tout_ff <= 1'b0;
    end else begin
      if (rx_push || rx_pop || rq_n_ff == 5'h00 || rst_ff != S_IDLE) begin
        to_ff <= 6'h00;
      end else if (tick && to_ff != TOUT_BITS) begin
        to_ff <= to_ff + 6'h01;
      end
      tout_ff <= tout_set || (tout_ff && !rx_pop &&
                 !(i_wr && ext && bank == 2'd0 && i_addr == OFF_AUX && i_wdata[0]));
    end
  end

  // Sticky line errors and modem deltas; a new event beats the read clear
  assign lerr_set = rx_done ? {!rxin && rdat == 8'h00, !rxin, rpe_ff, rq_n_ff >= rlim} : 4'h0;
  assign msd_set  = {m2_ff[3] ^ mprev_ff[3], mprev_ff[2] & ~m2_ff[2],
                     m2_ff[1] ^ mprev_ff[1], m2_ff[0] ^ mprev_ff[0]};

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      lerr_ff <= 4'h0;
      msd_ff  <= 4'h0;
      txe_ff  <= 1'b1;
    end else begin
      lerr_ff <= (lsr_rd ? 4'h0 : lerr_ff) | lerr_set;
      msd_ff  <= (msr_rd ? 4'h0 : msd_ff) | msd_set;
      txe_ff  <= tst_ff == S_IDLE && tq_n_ff == 5'h00;
    end
  end

  // Interrupt status: set wins over write-one clear
  always_comb begin
    ev         = 8'h00;
    ev[EV_RX]  = (rx_push && rq_n_ff + 5'h01 >= (fen ? thr : 5'h01)) || tout_set;
    ev[EV_TXL] = tx_pop && tq_n_ff == 5'h01;
    ev[EV_LS]  = |lerr_set;
    ev[EV_MS]  = |msd_set;
    ev[EV_TXE] = !txe_ff && tst_ff == S_IDLE && tq_n_ff == 5'h00;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ist_ff <= 8'h00;
      irq_ff <= 1'b0;
    end else begin
      ist_ff <= (ist_ff & ~((i_wr && bank == 2'd1 && i_addr == OFF_IST) ? i_wdata : 8'h00)) | ev;
      irq_ff <= |(ist_ff & ier_ff);
    end
  end

  // legacy identification is a priority code
  always_comb begin
    event_identification = {fen, fen, 6'h01};
    if ((ist_ff[EV_LS] && ier_ff[EV_LS])) begin
      event_identification[3:0] = 4'h6;
    end else if (ist_ff[EV_RX] && ier_ff[EV_RX]) begin
      event_identification[3:0] = {tout_ff, 3'h4};
    end else if (ist_ff[EV_TXL] && ier_ff[EV_TXL]) begin
      event_identification[3:0] = 4'h2;
    end else if (ist_ff[EV_MS] && ier_ff[EV_MS]) begin
      event_identification[3:0] = 4'h0;
    end
  end

  always_comb begin
    mux = 8'h00;
    if (i_addr == OFF_LCR) begin
      mux = bsel_ff[LCR_BANK_SELECT_ENABLE] ? bsel_ff : {1'b0, line_ff};
    end else begin
      case (bank)
        2'd0: begin
          case (i_addr)
            OFF_DATA: mux = rxq[rrp_ff].data;
            OFF_IER:  mux = ier_ff;
            OFF_EIR:  mux = ext ? (ist_ff & ier_ff) : event_identification;
            OFF_MCR:  mux = ext ? {4'h0, mcr_ff[3], 1'b0, mcr_ff[1:0]} : mcr_ff;
            OFF_LSR:  mux = {|lerr_ff[3:1], txe_ff, tq_n_ff == 5'h00, lerr_ff, rq_n_ff != 5'h00};
            OFF_MSR:  mux = {m2_ff, msd_ff};
            OFF_AUX:  mux = ext ? {7'h00, tout_ff} : spr_ff;
            default:  mux = 8'h00;
          endcase
        end
        2'd1: begin
          case (i_addr)
            OFF_DIVL: mux = ldiv_ff[7:0];
            OFF_DIVH: mux = ldiv_ff[15:8];
            OFF_IST:  mux = ist_ff;
            default:  mux = 8'h00;
          endcase
        end
        2'd2: begin
          case (i_addr)
            OFF_DIVL: mux = xdiv_ff[7:0];
            OFF_DIVH: mux = xdiv_ff[15:8];
            OFF_X1:   mux = x1_ff;
            OFF_X2:   mux = x2_ff;
            OFF_TXLV: mux = {4'h0, tq_n_ff[3:0]};
            OFF_RXLV: mux = {3'h0, rq_n_ff};
            default:  mux = 8'h00;
          endcase
        end
        default: begin
          case (i_addr)
            OFF_ID:   mux = {MOD_ID, REV_ID};
            OFF_SHLC: mux = {bsel_ff[LCR_BANK_SELECT_ENABLE], line_ff};
            OFF_SHFC: mux = fcr_ff;
            default:  mux = 8'h00;
          endcase
        end
      endcase
    end
  end

  // Output flops; loopback holds the line at mark
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_ff <= 8'h00;
      sout_ff  <= 1'b1;
      rts_ff   <= 1'b0;
      dtr_ff   <= 1'b0;
    end else begin
      rdata_ff <= i_rd ? mux : 8'h00;
      sout_ff  <= lpbk || (txo_ff && !line_ff.sbrk);
      rts_ff   <= mcr_ff[1] && !lpbk;
      dtr_ff   <= mcr_ff[0] && !lpbk;
    end
  end

  assign o_rdata = rdata_ff;
  assign o_sout  = sout_ff;
  assign o_rts   = rts_ff;
  assign o_dtr   = dtr_ff;
  assign o_irq   = irq_ff;

endmodule : bur_top

/* File: bur_pkg.sv */
// Shared constants and types of the banked UART register block
package bur_pkg;
  // Offsets common to several banks
  localparam logic [2:0] OFF_DATA = 3'h0;
  localparam logic [2:0] OFF_IER  = 3'h1;
  localparam logic [2:0] OFF_EIR  = 3'h2;
  localparam logic [2:0] OFF_LCR  = 3'h3;
  localparam logic [2:0] OFF_MCR  = 3'h4;
  localparam logic [2:0] OFF_LSR  = 3'h5;
  localparam logic [2:0] OFF_MSR  = 3'h6;
  localparam logic [2:0] OFF_AUX  = 3'h7;
  localparam logic [2:0] OFF_DIVL = 3'h0;
  localparam logic [2:0] OFF_DIVH = 3'h1;
  localparam logic [2:0] OFF_X1   = 3'h2;
  localparam logic [2:0] OFF_X2   = 3'h4;
  localparam logic [2:0] OFF_TXLV = 3'h6;
  localparam logic [2:0] OFF_RXLV = 3'h7;
  localparam logic [2:0] OFF_ID   = 3'h0;
  localparam logic [2:0] OFF_SHLC = 3'h1;
  localparam logic [2:0] OFF_SHFC = 3'h2;
  localparam logic [2:0] OFF_IST  = 3'h4;
  // Bank selector codes and field positions
  localparam logic [7:0] BSEL_B2  = 8'hE0;
  localparam logic [7:0] BSEL_B3  = 8'hE4;
  localparam int         LCR_BANK_SELECT_ENABLE = 7;
  localparam int         X1_EXT   = 0;
  localparam int         X1_LOOP  = 4;
  localparam int         MCR_LOOP = 4;
  localparam int         FCR_EN   = 0;
  localparam int         FCR_RXSR = 1;
  localparam int         FCR_TXSR = 2;
  localparam logic [7:0] FCR_KEEP = 8'hF9;
  localparam logic [7:0] IER_LEG  = 8'h0F;
  localparam logic [7:0] IER_EXT  = 8'h2F;
  // Event bit positions
  localparam int EV_RX  = 0;
  localparam int EV_TXL = 1;
  localparam int EV_LS  = 2;
  localparam int EV_MS  = 3;
  localparam int EV_TXE = 5;
  // Reset values
  localparam logic [15:0] RST_DIV  = 16'h0001;
  localparam logic [7:0]  RST_BYTE = 8'h00;
  // Identifier nibbles, values arbitrary
  localparam logic [3:0] MOD_ID = 4'h5;
  localparam logic [3:0] REV_ID = 4'h1;
  // Queue limits, receive thresholds, timeout in bit times
  localparam logic [4:0] TXQ_LIM = 5'h0F;
  localparam logic [4:0] RXQ_LIM = 5'h10;
  localparam logic [4:0] THR_0   = 5'h01;
  localparam logic [4:0] THR_1   = 5'h04;
  localparam logic [4:0] THR_2   = 5'h08;
  localparam logic [4:0] THR_3   = 5'h0E;
  localparam logic [5:0] TOUT_BITS = 6'h28;

  typedef struct packed {
    logic       sbrk;
    logic       stkp;
    logic       eps;
    logic       pen;
    logic       stb;
    logic [1:0] wls;
  } bur_line_t;

  typedef struct packed {
    logic       brk;
    logic       fe;
    logic       pe;
    logic [7:0] data;
  } bur_rxw_t;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_START = 3'b001,
    S_DATA  = 3'b011,
    S_PAR   = 3'b010,
    S_STOP  = 3'b110
  } bur_st_t;
endpackage : bur_pkg

/* File: bur_top_properties.sv */
// Port-level checker of the banked register window
`timescale 1ns/100ps
module bur_top_properties import bur_pkg::*; (
  // Clock and reset
  input wire logic       i_ref_clk,
  input wire logic       i_rst,
  // Register port
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  // Pins
  input wire logic       o_sout,
  input wire logic       o_irq
);
  logic [7:0] sel_ff;
  logic [6:0] line_ff;
  logic [1:0] bank;
  logic [7:0] rd_exp;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      sel_ff <= 8'h00;
    end else if (i_wr && i_addr == OFF_LCR) begin
      sel_ff <= i_wdata;
    end
  end

  // Line bits only move while the selector bit is clear
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      line_ff <= 7'h00;
    end else if (i_wr && i_addr == OFF_LCR && !i_wdata[7]) begin
      line_ff <= i_wdata[6:0];
    end
  end

  assign bank = !sel_ff[7] ? 2'd0 : !sel_ff[6] ? 2'd1 : (sel_ff[1] | sel_ff[0]) ? 2'd1 :
                (sel_ff == BSEL_B2) ? 2'd2 : (sel_ff == BSEL_B3) ? 2'd3 : 2'd0;
  assign rd_exp = sel_ff[7] ? sel_ff : {1'b0, line_ff};

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  chk_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  chk_sel_read: assert property (i_rd && i_addr == OFF_LCR |=> o_rdata == $past(rd_exp))
    else $error("selector location read back wrong");
  chk_id_read: assert property (i_rd && bank == 2'd3 && i_addr == OFF_ID |=> o_rdata == {MOD_ID, REV_ID})
    else $error("identifier byte wrong");
  chk_shadow_line: assert property (i_rd && bank == 2'd3 && i_addr == OFF_SHLC |=> o_rdata[6:0] == $past(line_ff))
    else $error("line control copy wrong");
  chk_txlv_width: assert property (i_rd && bank == 2'd2 && i_addr == OFF_TXLV |=> o_rdata[7:4] == 4'h0)
    else $error("transmit level upper bits set");
  chk_rxlv_width: assert property (i_rd && bank == 2'd2 && i_addr == OFF_RXLV |=> o_rdata <= 8'h10)
    else $error("receive level out of range");
  chk_bank1_resv: assert property (i_rd && bank == 2'd1 && (i_addr == 3'h2 || i_addr >= 3'h5) |=> o_rdata == 8'h00)
    else $error("reserved place in bank 1 not zero");
  chk_bank3_resv: assert property (i_rd && bank == 2'd3 && i_addr >= 3'h4 |=> o_rdata == 8'h00)
    else $error("reserved place in bank 3 not zero");
  chk_reset_idle: assert property (@(posedge i_ref_clk) disable iff (1'b0) i_rst |-> o_sout && !o_irq)
    else $error("pins not idle in reset");
endmodule : bur_top_properties

bind bur_top bur_top_properties i_chk (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_sout(o_sout), .o_irq(o_irq));

/* File: bur_far_end.sv */
// Behavioural remote serial peer, eight data bits, no parity, one stop
`timescale 1ns/100ps
module bur_far_end #(
  parameter int BIT_CLKS = 4
) (
  // Clock and link
  input  wire logic       i_ref_clk,
  input  wire logic       i_line,
  output logic            o_line,
  // Captured characters
  output logic      [7:0] o_got,
  output int              o_cnt
);
  initial begin
    o_line = 1'b1;
    o_got = 8'h00;
    o_cnt = 0;
  end

  always begin
    @(negedge i_line);
    repeat (BIT_CLKS / 2) @(posedge i_ref_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(posedge i_ref_clk);
      o_got[i] = i_line;
    end
    repeat (BIT_CLKS) @(posedge i_ref_clk);
    // Break frames lack a stop bit and are not counted
    if (i_line) begin
      o_cnt++;
    end
  end

  task automatic send(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge i_ref_clk);
      o_line <= fr[i];
      repeat (BIT_CLKS - 1) @(posedge i_ref_clk);
    end
  endtask : send
endmodule : bur_far_end

/* File: tb_banked_uart_register_interface.sv */
// Self-checking bench of the banked UART register block
`timescale 1ns/100ps
module tb_banked_uart_register_interface import bur_pkg::*;;
  logic       i_ref_clk;
  logic       i_rst;
  logic       i_wr;
  logic       i_rd;
  logic [2:0] i_addr;
  logic [7:0] i_wdata;
  logic [7:0] o_rdata;
  logic [3:0] i_modem;
  logic       sin;
  logic       o_sout;
  logic       o_rts;
  logic       o_dtr;
  logic       o_irq;
  logic [7:0] got;
  logic [7:0] rv;
  logic [7:0] code;
  logic [7:0] line_exp;
  logic [7:0] dat;
  logic [7:0] corner [7] = '{8'hE0, 8'hE4, 8'h80, 8'hC1, 8'hC2, 8'hE8, 8'h43};
  int         got_cnt;
  int         err_count;
  int         comparisons;
  int         cycles;
  int         seed;
  int         n;
  int         w;

  bur_top i_dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_sin(sin), .i_modem(i_modem), .o_sout(o_sout), .o_rts(o_rts),
    .o_dtr(o_dtr), .o_irq(o_irq));
  bur_far_end #(.BIT_CLKS(4)) i_far (.i_ref_clk(i_ref_clk), .i_line(o_sout), .o_line(sin), .o_got(got),
    .o_cnt(got_cnt));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rdchk(input logic [2:0] a, input logic [7:0] exp, input logic [7:0] mask);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1;
    check(o_rdata & mask, exp & mask);
  endtask : rdchk

  // Polls live signals; a by-value flag would never change
  task automatic wait_for(input bit on_irq, input int lim);
    w = 0;
    while ((on_irq ? o_irq !== 1'b1 : got_cnt == n) && w < lim) begin
      @(posedge i_ref_clk);
      w++;
    end
    if (w == lim) begin
      err_count++;
    end
  endtask : wait_for

  task automatic close_out();
    $display("Mismatches %0d, comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  function automatic logic [1:0] exp_bank(input logic [7:0] c);
    if (!c[7]) return 2'd0;
    if (!c[6] || c[1] || c[0]) return 2'd1;
    if (c == BSEL_B2) return 2'd2;
    return (c == BSEL_B3) ? 2'd3 : 2'd0;
  endfunction : exp_bank

  // Offset 1 differs in every bank, so it identifies the visible one
  function automatic logic [7:0] off1_exp(input logic [1:0] b);
    case (b)
      2'd0: return 8'h05;
      2'd1: return 8'h00;
      2'd2: return 8'h34;
      default: return line_exp;
    endcase
  endfunction : off1_exp

  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  initial begin
    cycles = 0;
    forever begin
      @(posedge i_ref_clk);
      cycles++;
      if (cycles == 20000) begin
        err_count++;
        close_out();
      end
    end
  end

  initial begin
    seed = 49062;
    err_count = 0;
    comparisons = 0;
    i_rst = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 3'h0;
    i_wdata = 8'h00;
    i_modem = 4'h0;
    line_exp = 8'h03;
    repeat (16) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    i_modem <= 4'($random(seed));
    rdchk(OFF_LCR, 8'h00, 8'hFF);
    wr(OFF_LCR, 8'h80);
    rdchk(OFF_DIVL, RST_DIV[7:0], 8'hFF);
    rdchk(OFF_DIVH, RST_DIV[15:8], 8'hFF);
    rdchk(3'h2, 8'h00, 8'hFF);
    wr(OFF_DIVL, 8'h04);
    wr(OFF_LCR, BSEL_B2);
    wr(OFF_DIVH, 8'h34);
    rdchk(OFF_DIVH, 8'h34, 8'hFF);
    rdchk(OFF_TXLV, 8'h00, 8'hFF);
    rdchk(OFF_RXLV, 8'h00, 8'hFF);
    wr(OFF_LCR, BSEL_B3);
    wr(OFF_ID, 8'hFF);
    rdchk(OFF_ID, {MOD_ID, REV_ID}, 8'hFF);
    rdchk(3'h5, 8'h00, 8'hFF);
    wr(OFF_LCR, 8'h03);
    wr(OFF_IER, 8'h05);
    wr(OFF_AUX, 8'h96);
    wr(OFF_EIR, 8'hC1);
    rdchk(OFF_EIR, 8'hC0, 8'hC0);
    rdchk(OFF_MSR, {i_modem, 4'h0}, 8'hF0);
    wr(OFF_MCR, 8'h03);
    @(posedge i_ref_clk);
    #1;
    check({6'h00, o_rts, o_dtr}, 8'h03);
    wr(OFF_LCR, BSEL_B3);
    rdchk(OFF_SHFC, 8'hC1, 8'hFF);
    rdchk(OFF_SHLC, 8'h03, 8'h7F);
    for (int k = 0; k < 14; k++) begin
      code = (k < 7) ? corner[k] : 8'($random(seed));
      wr(OFF_LCR, code);
      if (!code[7]) line_exp = code;
      rdchk(OFF_LCR, code[7] ? code : line_exp, 8'hFF);
      rdchk(OFF_IER, off1_exp(exp_bank(code)), 8'h7F);
    end
    wr(OFF_LCR, 8'h03);
    // A break code in the loop may have started a peer frame; let it end
    repeat (48) @(posedge i_ref_clk);
    rdchk(OFF_AUX, 8'h96, 8'hFF);
    wr(OFF_LCR, BSEL_B2);
    wr(OFF_X1, 8'h01);
    rdchk(OFF_X1, 8'h01, 8'hFF);
    wr(OFF_LCR, 8'h03);
    rdchk(OFF_AUX, 8'h00, 8'hFE);
    wr(OFF_LCR, BSEL_B2);
    wr(OFF_X1, 8'h00);
    wr(OFF_LCR, 8'h03);
    rdchk(OFF_AUX, 8'h96, 8'hFF);
    dat = 8'($random(seed));
    n = got_cnt;
    wr(OFF_DATA, dat);
    wait_for(1'b0, 300);
    check(got, dat);
    dat = 8'($random(seed));
    i_far.send(dat);
    repeat (4) @(posedge i_ref_clk);
    rdchk(OFF_LSR, 8'h01, 8'h01);
    wait_for(1'b1, 600);
    check({7'h00, o_irq}, 8'h01);
    wr(OFF_IER, 8'h00);
    repeat (2) @(posedge i_ref_clk);
    check({7'h00, o_irq}, 8'h00);
    rdchk(OFF_DATA, dat, 8'hFF);
    wr(OFF_LCR, 8'h80);
    wr(OFF_IST, 8'hFF);
    wr(OFF_LCR, 8'h03);
    wr(OFF_IER, 8'h05);
    repeat (3) @(posedge i_ref_clk);
    check({7'h00, o_irq}, 8'h00);
    close_out();
  end
endmodule : tb_banked_uart_register_interface
